// ==== src/scp_top.sv ====
// Serial configuration command port: frame decoder and register loops
`include "scp_params.svh"
module scp_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_in_i,
  output logic cmd_out_o,
  input wire logic autocal_busy_i,
  input wire logic [`SCP_W_MON-1:0] monitor_levels_i,
  input wire logic [`SCP_W_PED-1:0] ped_rdata_i,
  input wire logic spy_data_i,
  output scp_pkg::scp_cfg_t cfg_o,
  output scp_pkg::scp_ped_t ped_o,
  output logic soft_rst_o,
  output logic autocal_start_o,
  output logic [4:0] samplepos_eff_o,
  output logic spy_arm_o,
  output logic [2:0] spy_chip_sel_o,
  output logic spy_fire_o,
  output logic delay_tx_en_o,
  output logic delay_tx_data_o,
  output logic [1:0] ped_excl_cm_o,
  output logic [1:0] ped_excl_cluster_o
);
  import scp_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic cmd_m_r;
  logic cmd_s_r;
  logic spy_m_r;
  logic spy_s_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_m_r <= 1'b0;
      cmd_s_r <= 1'b0;
      spy_m_r <= 1'b0;
      spy_s_r <= 1'b0;
    end
    else
    begin
      cmd_m_r <= cmd_in_i;
      cmd_s_r <= cmd_m_r;
      spy_m_r <= spy_data_i;
      spy_s_r <= spy_m_r;
    end
  end

  // ****************************************************************
  // Frame decoder
  // ****************************************************************
  scp_state_t state_r;
  logic rw_r;
  logic [4:0] desig_r;
  logic [15:0] len_r;
  logic [3:0] fcnt_r;
  logic [15:0] len_in;
  logic args_start;
  logic cmd_done;

  always_comb
  begin
    len_in = {len_r[14:0], cmd_s_r};
    args_start = (state_r == SCP_LEN) && (fcnt_r == `SCP_LEN_LAST) &&
                 (len_in != 16'h0000);
    cmd_done = ((state_r == SCP_ARGS) && (len_r == 16'h0001)) ||
               ((state_r == SCP_LEN) && (fcnt_r == `SCP_LEN_LAST) &&
                (len_in == 16'h0000));
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= SCP_IDLE;
      rw_r <= 1'b0;
      desig_r <= 5'h00;
      len_r <= 16'h0000;
      fcnt_r <= 4'h0;
    end
    else
    begin
      unique case (state_r)
        SCP_IDLE:
          if (cmd_s_r)
            state_r <= SCP_RW;
        SCP_RW:
        begin
          rw_r <= cmd_s_r;
          fcnt_r <= 4'h0;
          state_r <= SCP_DESIG;
        end
        SCP_DESIG:
        begin
          desig_r <= {desig_r[3:0], cmd_s_r};
          fcnt_r <= fcnt_r + 4'h1;
          if (fcnt_r == `SCP_DESIG_LAST)
            state_r <= SCP_MARK;
        end
        SCP_MARK:
        begin
          fcnt_r <= 4'h0;
          state_r <= SCP_LEN;
        end
        SCP_LEN:
        begin
          len_r <= len_in;
          fcnt_r <= fcnt_r + 4'h1;
          if (fcnt_r == `SCP_LEN_LAST)
            state_r <= (len_in == 16'h0000) ? SCP_IDLE : SCP_ARGS;
        end
        SCP_ARGS:
        begin
          len_r <= len_r - 16'h0001;
          if (len_r == 16'h0001)
            state_r <= SCP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Register loops
  // ****************************************************************
  logic in_args;
  logic [179:0] q_delay;
  logic [23:0] q_fiben;
  logic [4:0] q_spos;
  logic [119:0] q_thr;
  logic [0:0] q_thren;
  logic [239:0] q_cm;
  logic [0:0] q_cmen;
  logic [35:0] q_ped;
  logic [11:0] q_padr;
  logic [191:0] q_nval;
  logic [4:0] q_mode;
  logic [9:0] q_scope;
  logic [11:0] q_nsamp;
  logic [0:0] q_coarse;
  logic [144:0] q_mon;
  logic [2:0] q_spy;
  logic [0:0] q_cal;
  logic act_r;
  logic [4:0] act_desig_r;
  logic act_rw_r;
  logic padr_inc;

  assign in_args = (state_r == SCP_ARGS);
  assign padr_inc = act_r && (act_desig_r == `SCP_D_PEDDAT);

  // Only the designated loop shifts; unused codes select none
  scp_shift_loop #(.W(`SCP_W_DELAY)) u_delay (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_DELAY), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_delay));
  scp_shift_loop #(.W(`SCP_W_FIBEN)) u_fiben (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_FIBEN), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_fiben));
  scp_shift_loop #(.W(`SCP_W_SPOS), .RST(`SCP_SPOS_RST)) u_spos (
    .clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_SPOS), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_spos));
  scp_shift_loop #(.W(`SCP_W_THR)) u_thr (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_THR), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_thr));
  scp_shift_loop #(.W(1)) u_thren (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_THREN), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_thren));
  scp_shift_loop #(.W(`SCP_W_CM)) u_cm (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_CM), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_cm));
  scp_shift_loop #(.W(1)) u_cmen (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_CMEN), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_cmen));
  // Pedestal word is fetched from memory before its arguments shift
  scp_shift_loop #(.W(`SCP_W_PED)) u_ped (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_PEDDAT), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(args_start && desig_r == `SCP_D_PEDDAT),
    .load_d_i(ped_rdata_i), .q_o(q_ped));
  scp_shift_loop #(.W(`SCP_W_PEDADR)) u_padr (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_PEDADR), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(padr_inc),
    .load_d_i(q_padr + 12'h001), .q_o(q_padr));
  scp_shift_loop #(.W(`SCP_W_NVALID)) u_nval (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_NVALID), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_nval));
  scp_shift_loop #(.W(`SCP_W_MODE)) u_mode (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_MODE), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_mode));
  scp_shift_loop #(.W(`SCP_W_SCOPE)) u_scope (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_SCOPE), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_scope));
  scp_shift_loop #(.W(`SCP_W_NSAMP)) u_nsamp (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_NSAMP), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_nsamp));
  scp_shift_loop #(.W(1)) u_coarse (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_COARSE), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_coarse));
  // Monitor loop always recirculates a snapshot of the buffer levels
  scp_shift_loop #(.W(`SCP_W_MON)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_MON), .recirc_i(1'b1),
    .bit_i(cmd_s_r), .load_i(args_start && desig_r == `SCP_D_MON),
    .load_d_i(monitor_levels_i), .q_o(q_mon));
  scp_shift_loop #(.W(`SCP_W_SPY)) u_spy (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_SPYARM), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(1'b0), .load_d_i('0), .q_o(q_spy));
  // Calibration loop is loaded with the busy flag so a read polls it
  scp_shift_loop #(.W(1)) u_cal (.clk_i(clk_i), .rst_i(rst_i),
    .shift_i(in_args && desig_r == `SCP_D_CAL), .recirc_i(rw_r),
    .bit_i(cmd_s_r), .load_i(args_start && desig_r == `SCP_D_CAL),
    .load_d_i(autocal_busy_i), .q_o(q_cal));

  // Loops drive the outputs live, so they move during a command
  always_comb
  begin
    cfg_o.delay = q_delay;
    cfg_o.fibre_en = q_fiben;
    cfg_o.sample_pos = q_spos;
    cfg_o.thresh = q_thr;
    cfg_o.thresh_en = q_thren[0];
    cfg_o.cm = q_cm;
    cfg_o.cm_en = q_cmen[0];
    cfg_o.num_valid = q_nval;
    cfg_o.mode = q_mode;
    cfg_o.scope_len = q_scope;
    cfg_o.num_samples = q_nsamp;
    cfg_o.auto_coarse = q_coarse[0];
  end

  // ****************************************************************
  // Serial echo
  // ****************************************************************
  logic echo;

  always_comb
  begin
    echo = 1'b0;
    case (desig_r)
      `SCP_D_DELAY: echo = q_delay[`SCP_W_DELAY-1];
      `SCP_D_FIBEN: echo = q_fiben[`SCP_W_FIBEN-1];
      `SCP_D_SPOS: echo = q_spos[`SCP_W_SPOS-1];
      `SCP_D_THR: echo = q_thr[`SCP_W_THR-1];
      `SCP_D_THREN: echo = q_thren[0];
      `SCP_D_CM: echo = q_cm[`SCP_W_CM-1];
      `SCP_D_CMEN: echo = q_cmen[0];
      `SCP_D_PEDDAT: echo = q_ped[`SCP_W_PED-1];
      `SCP_D_PEDADR: echo = q_padr[`SCP_W_PEDADR-1];
      `SCP_D_NVALID: echo = q_nval[`SCP_W_NVALID-1];
      `SCP_D_MODE: echo = q_mode[`SCP_W_MODE-1];
      `SCP_D_SCOPE: echo = q_scope[`SCP_W_SCOPE-1];
      `SCP_D_NSAMP: echo = q_nsamp[`SCP_W_NSAMP-1];
      `SCP_D_COARSE: echo = q_coarse[0];
      `SCP_D_MON: echo = q_mon[`SCP_W_MON-1];
      `SCP_D_CAL: echo = q_cal[0];
      `SCP_D_SPYFIRE: echo = spy_s_r;
      default: echo = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cmd_out_o <= 1'b0;
    else
      cmd_out_o <= in_args && echo;
  end

  // ****************************************************************
  // End-of-command actions, one cycle after the last bit
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      act_r <= 1'b0;
      act_desig_r <= 5'h00;
      act_rw_r <= 1'b0;
    end
    else
    begin
      act_r <= cmd_done;
      act_desig_r <= desig_r;
      act_rw_r <= rw_r;
    end
  end

  // Soft reset high for exactly the argument bits of its frame
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      soft_rst_o <= 1'b0;
    else
      soft_rst_o <= in_args && desig_r == `SCP_D_SOFT;
  end

  // Calibration start; offset latched so later edits do not matter
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      autocal_start_o <= 1'b0;
      samplepos_eff_o <= 5'h00;
    end
    else
    begin
      autocal_start_o <= act_r && !act_rw_r &&
                         act_desig_r == `SCP_D_CAL && q_cal[0];
      if (act_r && !act_rw_r && act_desig_r == `SCP_D_CAL && q_cal[0])
        samplepos_eff_o <= q_coarse[0] ? q_spos : 5'h00;
    end
  end

  // ****************************************************************
  // Spy capture control
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      spy_arm_o <= 1'b0;
      spy_chip_sel_o <= 3'h0;
      spy_fire_o <= 1'b0;
    end
    else
    begin
      spy_arm_o <= act_r && act_desig_r == `SCP_D_SPYARM &&
                   q_spy[2];
      if (act_r && act_desig_r == `SCP_D_SPYARM)
        spy_chip_sel_o <= (q_spy[1:0] == `SCP_CHIP_ALL) ? 3'h7 :
                          3'(3'h1 << q_spy[1:0]);
      // Readback streams the chip's serial data during the frame's argument bits
      spy_fire_o <= in_args && desig_r == `SCP_D_SPYFIRE;
    end
  end

  // ****************************************************************
  // Delay chip transmission
  // ****************************************************************
  logic [`SCP_W_TXSNAP-1:0] fwd;
  logic [`SCP_W_TXSNAP-1:0] tx_snap_r;
  logic [7:0] tx_cnt_r;

  // Low nine bits of each fifteen-bit word, first fibre first
  always_comb
  begin
    fwd = '0;
    for (int i = 0; i < `SCP_FIBRES; i++)
      fwd[i*`SCP_FWD_W +: `SCP_FWD_W] =
        q_delay[i*`SCP_DWORD_W +: `SCP_FWD_W];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_cnt_r <= 8'h00;
      tx_snap_r <= '0;
      delay_tx_en_o <= 1'b0;
      delay_tx_data_o <= 1'b0;
    end
    else if (act_r && act_desig_r == `SCP_D_DELAY)
    begin
      tx_cnt_r <= `SCP_DTX_CYCLES;
      tx_snap_r <= fwd;
      delay_tx_en_o <= 1'b0;
      delay_tx_data_o <= 1'b0;
    end
    else if (tx_cnt_r != 8'h00)
    begin
      tx_cnt_r <= tx_cnt_r - 8'h01;
      tx_snap_r <= {tx_snap_r[`SCP_W_TXSNAP-2:0], 1'b0};
      delay_tx_en_o <= 1'b1;
      delay_tx_data_o <= tx_snap_r[`SCP_W_TXSNAP-1];
    end
    else
    begin
      delay_tx_en_o <= 1'b0;
      delay_tx_data_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Pedestal memory port
  // ****************************************************************
  logic [5:0] we_mask;

  always_comb
  begin
    if (q_padr[`SCP_PA_MEM_HI:`SCP_PA_MEM_LO] == `SCP_MEM_ALL)
      we_mask = `SCP_WE_ALL;
    else if (q_padr[`SCP_PA_MEM_HI:`SCP_PA_MEM_LO] < 3'(`SCP_MEM_CNT))
      we_mask = 6'(6'h01 << q_padr[`SCP_PA_MEM_HI:`SCP_PA_MEM_LO]);
    else
      we_mask = 6'h00;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ped_o <= '0;
    else
    begin
      ped_o.addr <= q_padr;
      ped_o.wdata <= q_ped;
      ped_o.we <= (padr_inc && !act_rw_r) ? we_mask : 6'h00;
    end
  end

  // Strip exclusion flags decoded from the current word
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ped_excl_cm_o <= 2'h0;
      ped_excl_cluster_o <= 2'h0;
    end
    else if (!q_padr[`SCP_PA_HALF])
    begin
      ped_excl_cm_o <= {!q_ped[`SCP_PED_V1], !q_ped[`SCP_PED_V0]};
      ped_excl_cluster_o <= {!q_ped[`SCP_PED_V1],
                             !q_ped[`SCP_PED_V0]};
    end
    else
    begin
      ped_excl_cm_o <= 2'h0;
      ped_excl_cluster_o <= {
        q_ped[`SCP_CT1_HI:`SCP_CT1_LO] == `SCP_CT_EXCL,
        q_ped[`SCP_CT0_HI:`SCP_CT0_LO] == `SCP_CT_EXCL};
    end
  end
endmodule

// ==== src/scp_params.svh ====
// Constants of the serial configuration command port
// Operation
// - Frame: one, flag, designator, one, length, arguments
// - Every field travels most significant bit first
// - Selected register loops echo old contents out; spy arm loop echoes zeros
// - Read-only flag recirculates, ignores incoming arguments
// - Registers change while bits shift, no copy
// - Delay load: twelve words, low nine forwarded
// - Delays then sent to chips over 160 cycles
// - Fibre enable: two-bit code per fibre
// - Sample offset: hard reset five, soft keeps
// - Offset used only with coarse flag, latched
// - Twelve threshold overrides plus one enable bit
// - Twenty-four common-mode overrides plus enable bit
// - Spy arm tells chips to capture continuously
// - Chip select: 0,1,2 one chip, 3 all
// - Spy readback from one chip occupies line
// - Spy words interleaved by word index
// - Soft reset lasts length cycles, spares configuration
// - Pedestal word access, then address auto-increments
// - Address bit eight picks pedestal or thresholds
// - Invalid strip excludes common mode and clustering; threshold 255 excludes clustering only
// - Address: memory, half, strip fields
// - Memory select 111 writes all six memories
// - Mode bits pick output format and capture
// - Calibration command read returns busy flag
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// ****************************************************************
// Command designators
// ****************************************************************
`define SCP_D_DELAY 5'h01
`define SCP_D_FIBEN 5'h02
`define SCP_D_SPOS 5'h03
`define SCP_D_THR 5'h04
`define SCP_D_THREN 5'h05
`define SCP_D_SPYARM 5'h07
`define SCP_D_SPYFIRE 5'h08
`define SCP_D_CM 5'h0A
`define SCP_D_CMEN 5'h0B
`define SCP_D_SOFT 5'h0C
`define SCP_D_PEDDAT 5'h0D
`define SCP_D_PEDADR 5'h0E
`define SCP_D_NVALID 5'h0F
`define SCP_D_MODE 5'h10
`define SCP_D_SCOPE 5'h11
`define SCP_D_CAL 5'h12
`define SCP_D_NSAMP 5'h13
`define SCP_D_MON 5'h14
`define SCP_D_COARSE 5'h15

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define SCP_DESIG_LAST 4'h4
`define SCP_LEN_LAST 4'hF
`define SCP_W_DELAY 180
`define SCP_DWORD_W 15
`define SCP_FWD_W 9
`define SCP_FIBRES 12
`define SCP_W_TXSNAP 108
`define SCP_W_FIBEN 24
`define SCP_W_SPOS 5
`define SCP_W_THR 120
`define SCP_W_CM 240
`define SCP_W_PED 36
`define SCP_W_PEDADR 12
`define SCP_W_NVALID 192
`define SCP_W_MODE 5
`define SCP_W_SCOPE 10
`define SCP_W_NSAMP 12
`define SCP_W_MON 145
`define SCP_W_SPY 3
`define SCP_PA_MEM_HI 11
`define SCP_PA_MEM_LO 9
`define SCP_PA_HALF 8
`define SCP_PED_V1 28
`define SCP_PED_V0 10
`define SCP_CT1_HI 25
`define SCP_CT1_LO 18
`define SCP_CT0_HI 7
`define SCP_CT0_LO 0
`define SCP_CT_EXCL 8'hFF
`define SCP_MEM_ALL 3'h7
`define SCP_MEM_CNT 6
`define SCP_WE_ALL 6'h3F
`define SCP_CHIP_ALL 2'h3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define SCP_SPOS_RST 5'h05
`define SCP_DTX_CYCLES 8'hA0

`endif

// ==== src/scp_pkg.sv ====
// Types of the serial configuration command port
package scp_pkg;

  typedef enum logic [5:0] {
    SCP_IDLE = 6'h01,
    SCP_RW = 6'h02,
    SCP_DESIG = 6'h04,
    SCP_MARK = 6'h08,
    SCP_LEN = 6'h10,
    SCP_ARGS = 6'h20
  } scp_state_t;

  typedef struct packed {
    logic [179:0] delay;
    logic [23:0] fibre_en;
    logic [4:0] sample_pos;
    logic [119:0] thresh;
    logic thresh_en;
    logic [239:0] cm;
    logic cm_en;
    logic [191:0] num_valid;
    logic [4:0] mode;
    logic [9:0] scope_len;
    logic [11:0] num_samples;
    logic auto_coarse;
  } scp_cfg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [35:0] wdata;
    logic [5:0] we;
  } scp_ped_t;

endpackage

// ==== src/scp_shift_loop.sv ====
// Shift loop register for one configuration command
module scp_shift_loop
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic shift_i,
  input wire logic recirc_i,
  input wire logic bit_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_d_i,
  output logic [W-1:0] q_o
);
  logic in_bit;
  logic [W:0] cat;

  always_comb
  begin
    in_bit = recirc_i ? q_o[W-1] : bit_i;
    cat = {q_o, in_bit};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q_o <= RST;
    else if (load_i)
      q_o <= load_d_i;
    else if (shift_i)
      q_o <= cat[W-1:0];
  end
endmodule

// ==== testbench/scp_top_sva.sv ====
// Checker bound to the command port top module
`include "scp_params.svh"
module scp_top_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire scp_pkg::scp_cfg_t cfg_o,
  input wire scp_pkg::scp_ped_t ped_o,
  input wire logic soft_rst_o,
  input wire logic autocal_start_o,
  input wire logic [4:0] samplepos_eff_o,
  input wire logic spy_arm_o,
  input wire logic [2:0] spy_chip_sel_o,
  input wire logic delay_tx_en_o,
  input wire logic [1:0] ped_excl_cm_o,
  input wire logic [1:0] ped_excl_cluster_o
);
  import scp_pkg::*;
  logic [7:0] tx_run_r;
  // Length of the current delay transmission burst
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tx_run_r <= 8'h00;
    else if (delay_tx_en_o)
      tx_run_r <= tx_run_r + 8'h01;
    else
      tx_run_r <= 8'h00;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  tx_len_a: assert property (
    $fell(delay_tx_en_o) |-> tx_run_r == `SCP_DTX_CYCLES)
    else $error("delay transmit burst length wrong");
  sample_rst_a: assert property (
    $past(rst_i) |-> cfg_o.sample_pos == `SCP_SPOS_RST)
    else $error("sample offset reset value wrong");
  spy_sel_a: assert property (
    $onehot0(spy_chip_sel_o) || spy_chip_sel_o == 3'h7)
    else $error("chip select code illegal");
  soft_cfg_a: assert property (
    soft_rst_o |=> $stable(cfg_o))
    else $error("soft reset disturbed configuration");
  we_pulse_a: assert property (
    ped_o.we != 6'h00 |=> ped_o.we == 6'h00)
    else $error("pedestal write strobe too long");
  we_code_a: assert property (
    $onehot0(ped_o.we) || ped_o.we == `SCP_WE_ALL)
    else $error("pedestal write strobe code illegal");
  excl_both_a: assert property (
    (ped_excl_cm_o & ~ped_excl_cluster_o) == 2'h0)
    else $error("invalid strip kept in clustering");
  arm_pulse_a: assert property (
    spy_arm_o |=> !spy_arm_o)
    else $error("spy arm pulse too long");
  eff_latch_a: assert property (
    $changed(samplepos_eff_o) |-> autocal_start_o || $past(autocal_start_o))
    else $error("effective offset changed without start");
endmodule
bind scp_top scp_top_sva scp_top_sva_inst (.clk_i, .rst_i, .cfg_o, .ped_o,
  .soft_rst_o, .autocal_start_o, .samplepos_eff_o, .spy_arm_o,
  .spy_chip_sel_o, .delay_tx_en_o, .ped_excl_cm_o, .ped_excl_cluster_o);

// ==== testbench/scp_ctrl_model.sv ====
// Controller model driving the serial command line
module scp_ctrl_model
(
  input wire logic clk_i,
  input wire logic cmd_out_i,
  output logic cmd_in_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cmd_in_o = 1'b0;
  // Sends one whole frame and collects the echoed old contents
  task automatic send(input logic rw, input logic [4:0] d,
    input logic [15:0] len, input logic [255:0] a, output logic [255:0] e);
    logic [23:0] h;
    h = {1'b1, rw, d, 1'b1, len};
    e = '0;
    for (int k = 0; k < 27 + len; k++)
    begin
      @(posedge clk_i);
      #1;
      if (k < 24)
        cmd_in_o = h[23 - k];
      else if (k < 24 + len)
        cmd_in_o = a[len + 23 - k];
      else
        cmd_in_o = 1'b0;
      if (k >= 27)
        e = {e[254:0], cmd_out_i};
    end
  endtask
endmodule

// ==== testbench/scp_top_tb.sv ====
// Self-checking bench for the serial configuration command port
`include "scp_params.svh"
module scp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic autocal_busy_i = 1'b0;
  logic cmd_in_i, cmd_out_o, soft_rst_o, autocal_start_o, spy_arm_o;
  logic spy_fire_o, delay_tx_en_o, delay_tx_data_o;
  logic [4:0] samplepos_eff_o;
  logic [2:0] spy_chip_sel_o;
  logic [1:0] ped_excl_cm_o, ped_excl_cluster_o;
  scp_cfg_t cfg_o, c;
  scp_ped_t ped_o;
  logic [255:0] e, m;
  logic [255:0] p = {8{32'hA5C396E1}};
  logic [5:0] we_seen;
  logic spy_in = 1'b0;
  int fail_count = 0, n_compared = 0, tx_cnt = 0, sr_cnt = 0, arm_n = 0;
  int sf_n = 0, st_n = 0, tx_ones = 0;
  logic [4:0] dl [12] = '{`SCP_D_DELAY, `SCP_D_FIBEN, `SCP_D_SPOS,
    `SCP_D_THR, `SCP_D_THREN, `SCP_D_CM, `SCP_D_CMEN, `SCP_D_NVALID,
    `SCP_D_MODE, `SCP_D_SCOPE, `SCP_D_NSAMP, `SCP_D_COARSE};
  logic [15:0] ln [12] = '{180, 24, 5, 120, 1, 240, 1, 192, 5, 10, 12, 1};
  always #5 clk_i = ~clk_i;
  scp_top scp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_in_i(cmd_in_i),
    .cmd_out_o(cmd_out_o), .autocal_busy_i(autocal_busy_i),
    .monitor_levels_i(p[144:0]), .ped_rdata_i(p[35:0]),
    .spy_data_i(spy_in),
    .cfg_o(cfg_o), .ped_o(ped_o), .soft_rst_o(soft_rst_o),
    .autocal_start_o(autocal_start_o), .samplepos_eff_o(samplepos_eff_o),
    .spy_arm_o(spy_arm_o), .spy_chip_sel_o(spy_chip_sel_o),
    .spy_fire_o(spy_fire_o), .delay_tx_en_o(delay_tx_en_o),
    .delay_tx_data_o(delay_tx_data_o), .ped_excl_cm_o(ped_excl_cm_o),
    .ped_excl_cluster_o(ped_excl_cluster_o));
  scp_ctrl_model scp_ctrl_model_inst (.clk_i(clk_i), .cmd_out_i(cmd_out_o),
    .cmd_in_o(cmd_in_i));
  // ****************
  // Helpers
  // ****************
  always @(posedge clk_i)
  begin
    tx_cnt += (delay_tx_en_o === 1'b1);
    sr_cnt += (soft_rst_o === 1'b1);
    arm_n += (spy_arm_o === 1'b1);
    sf_n += (spy_fire_o === 1'b1);
    st_n += (autocal_start_o === 1'b1);
    tx_ones += (delay_tx_en_o === 1'b1 && delay_tx_data_o === 1'b1);
    we_seen |= ped_o.we;
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic rw, input logic [4:0] d,
    input logic [15:0] len, input logic [255:0] a);
    scp_ctrl_model_inst.send(rw, d, len, a, e);
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [255:0] fld(input logic [4:0] d);
    case (d)
      `SCP_D_DELAY: fld = cfg_o.delay;
      `SCP_D_FIBEN: fld = cfg_o.fibre_en;
      `SCP_D_SPOS: fld = cfg_o.sample_pos;
      `SCP_D_THR: fld = cfg_o.thresh;
      `SCP_D_THREN: fld = cfg_o.thresh_en;
      `SCP_D_CM: fld = cfg_o.cm;
      `SCP_D_CMEN: fld = cfg_o.cm_en;
      `SCP_D_NVALID: fld = cfg_o.num_valid;
      `SCP_D_MODE: fld = cfg_o.mode;
      `SCP_D_SCOPE: fld = cfg_o.scope_len;
      `SCP_D_NSAMP: fld = cfg_o.num_samples;
      default: fld = cfg_o.auto_coarse;
    endcase
  endfunction
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      m = (256'h1 << ln[i]) - 256'h1;
      cmd(1'b0, dl[i], ln[i], ~p & m);
      chk(e, (dl[i] == `SCP_D_SPOS) ? 256'h5 : 256'h0);
      cmd(1'b0, dl[i], ln[i], p & m);
      chk(e, ~p & m);
      chk(fld(dl[i]), p & m);
    end
    cmd(1'b1, `SCP_D_SPOS, 16'h0005, 256'h1F);
    chk(e, 256'h01);
    chk(cfg_o.sample_pos, 256'h01);
    $display("test loops done");
    c = cfg_o;
    sr_cnt = 0;
    cmd(1'b0, 5'h06, 16'h0008, 256'hFF);
    chk(e, 256'h0);
    cmd(1'b0, `SCP_D_SOFT, 16'h0005, 256'h1F);
    chk(sr_cnt, 256'h5);
    chk(cfg_o === c, 256'h1);
    $display("test soft reset done");
    for (int k = 2; k < 8; k += 5)
    begin
      cmd(1'b0, `SCP_D_PEDADR, 16'h000C, {k[2:0], 9'h005});
      we_seen = '0;
      cmd(1'b0, `SCP_D_PEDDAT, 16'h0024, 36'h8_0155_02AA);
      chk(we_seen, (k == 7) ? 256'h3F : 256'h04);
      chk(ped_o.wdata, 36'h8_0155_02AA);
      chk(ped_o.addr, {k[2:0], 9'h006});
    end
    // Read returns the fetched word, writes nothing, still advances
    we_seen = '0;
    cmd(1'b1, `SCP_D_PEDDAT, 16'h0024, 256'h0);
    chk(e, p[35:0]);
    chk(we_seen, 256'h0);
    chk(ped_o.addr, 12'hE07);
    chk(ped_excl_cm_o, 256'h2);
    chk(ped_excl_cluster_o, 256'h2);
    cmd(1'b0, `SCP_D_PEDADR, 16'h000C, 256'h100);
    cmd(1'b0, `SCP_D_PEDDAT, 16'h0024, 36'h0_03FC_00FE);
    chk(ped_excl_cm_o, 256'h0);
    chk(ped_excl_cluster_o, 256'h2);
    $display("test pedestal done");
    autocal_busy_i = 1'b1;
    cmd(1'b0, `SCP_D_CAL, 16'h0001, 256'h1);
    chk(samplepos_eff_o, 256'h01);
    cmd(1'b0, `SCP_D_SPOS, 16'h0005, 256'h0A);
    chk(samplepos_eff_o, 256'h01);
    cmd(1'b1, `SCP_D_CAL, 16'h0001, 256'h0);
    chk(e, 256'h1);
    chk(st_n, 256'h1);
    $display("test calibration done");
    cmd(1'b1, `SCP_D_MON, 16'h0091, 256'h0);
    chk(e, p[144:0]);
    spy_in = 1'b1;
    cmd(1'b0, `SCP_D_SPYFIRE, 16'h0008, 256'h0);
    chk(e, 256'hFF);
    chk(sf_n, 256'h8);
    $display("test monitor and spy readback done");
    for (int k = 0; k < 4; k++)
    begin
      cmd(1'b0, `SCP_D_SPYARM, 16'h0003, {1'b1, k[1:0]});
      chk(spy_chip_sel_o, (k == 3) ? 256'h7 : (256'h1 << k));
      chk(arm_n, k + 1);
    end
    repeat (200) @(posedge clk_i);
    chk(tx_cnt, 256'd320);
    chk(tx_ones, 256'd108);
    $display("test spy and delay done");
    test_done();
  end
endmodule
